// ===== kiu_map.svh
// Register map, field positions, reset values and bus responses of the keypad interrupt unit
`ifndef KIU_MAP_SVH
`define KIU_MAP_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define KIU_ADDR_W      8
`define KIU_SCR_OFF     8'h00
`define KIU_PEN_OFF     8'h04
`define KIU_EVT_OFF     8'h08
`define KIU_EMASK_OFF   8'h0C

// ****************************************************************
// Field positions
// ****************************************************************
`define KIU_SENS_BIT    0
`define KIU_MASK_BIT    1
`define KIU_ACK_BIT     2
`define KIU_PEND_BIT    3
`define KIU_PINS        4

// ****************************************************************
// Reset values and bus answers
// ****************************************************************
`define KIU_PEN_RST     4'h0
`define KIU_PIN_IDLE    4'hF
`define KIU_RESP_OKAY   2'h0
`define KIU_RESP_SLVERR 2'h2

`endif

// ===== kiu_pkg.sv
// Types shared by the keypad interrupt unit
package kiu_pkg;

  // Software controls of the status and control register
  typedef struct packed {
    logic mask;
    logic sens;
  } kiu_ctrl_t;

  // Sticky events, same layout for status and mask
  typedef struct packed {
    logic lost;
    logic latched;
  } kiu_evt_t;

  // Write channel sequence
  typedef enum logic [1:0] {
    WR_COLLECT = 2'b00,
    WR_RESP    = 2'b01
  } kiu_wst_t;

  // Read channel sequence
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_RESP = 2'b01
  } kiu_rst_t;

endpackage : kiu_pkg

// ===== kiu_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none

module kiu_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Pins and filtered levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_d;

  // Level only moves once stages two and three agree
  always_comb begin
    q_d = q_o;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        q_d[i] = s3_q[i];
      end
    end
  end

  // Idle high, as the pins rest with pull-ups
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      q_o  <= '1;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_o  <= q_d;
    end
  end

endmodule : kiu_sync

`default_nettype wire

// ===== kiu_top.sv
// Keypad interrupt unit with AXI4-Lite register slave
`timescale 1ns/10ps
`default_nettype none
`include "kiu_map.svh"

module kiu_top (
  // Clock and reset
  input  wire logic                   CORE_CLK_I,
  input  wire logic                   RESETN_I,
  // AXI4-Lite write address and data
  input  wire logic [`KIU_ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic                   S_AXI_AWVALID,
  output logic                        S_AXI_AWREADY,
  input  wire logic [31:0]            S_AXI_WDATA,
  input  wire logic [3:0]             S_AXI_WSTRB,
  input  wire logic                   S_AXI_WVALID,
  output logic                        S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0]                  S_AXI_BRESP,
  output logic                        S_AXI_BVALID,
  input  wire logic                   S_AXI_BREADY,
  // AXI4-Lite read
  input  wire logic [`KIU_ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic                   S_AXI_ARVALID,
  output logic                        S_AXI_ARREADY,
  output logic [31:0]                 S_AXI_RDATA,
  output logic [1:0]                  S_AXI_RRESP,
  output logic                        S_AXI_RVALID,
  input  wire logic                   S_AXI_RREADY,
  // Keypad pins and CPU side
  input  wire logic [`KIU_PINS-1:0]   PORT_PIN_I,
  input  wire logic                   VECTOR_FETCH_I,
  input  wire logic                   WAIT_MODE_I,
  input  wire logic                   STOP_MODE_I,
  output logic                        KEY_IRQ_O,
  output logic                        WAKE_O,
  output logic                        IRQ_O
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic [1:0] rs_q;
  logic       rst_n;

  // Asynchronous assert, two-flop release
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rs_q <= 2'h0;
    end else begin
      rs_q <= {rs_q[0], 1'b1};
    end
  end
  assign rst_n = rs_q[1];

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  logic [`KIU_PINS-1:0] pin_lvl;

  kiu_sync #(.W(`KIU_PINS)) u_sync (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (rst_n),
    .d_i     (PORT_PIN_I),
    .q_o     (pin_lvl)
  );

  // ****************************************************************
  // Write channel
  // ****************************************************************
  kiu_pkg::kiu_wst_t    wst_q, wst_d;
  logic                 aw_got_q, aw_got_d;
  logic                 w_got_q, w_got_d;
  logic [`KIU_ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0]          wdata_q, wdata_d;
  logic                 wstrb0_q, wstrb0_d;
  logic                 awready_d, wready_d, bvalid_d;
  logic [1:0]           bresp_q, bresp_d;
  logic                 wr_go, wr_scr, wr_pen, wr_emask, wr_ok;

  // Both halves held until each is present, in either order
  assign wr_go    = (wst_q == kiu_pkg::WR_COLLECT) && aw_got_q && w_got_q;
  assign wr_scr   = wr_go && wstrb0_q && (awaddr_q == `KIU_SCR_OFF);
  assign wr_pen   = wr_go && wstrb0_q && (awaddr_q == `KIU_PEN_OFF);
  assign wr_emask = wr_go && wstrb0_q && (awaddr_q == `KIU_EMASK_OFF);

  // Address decode for the response code
  always_comb begin
    if ((awaddr_q == `KIU_SCR_OFF) || (awaddr_q == `KIU_PEN_OFF)) begin
      wr_ok = 1'b1;
    end else if ((awaddr_q == `KIU_EVT_OFF) || (awaddr_q == `KIU_EMASK_OFF)) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0;
    end
  end

  // Next state of the write channel
  always_comb begin
    wst_d    = wst_q;
    aw_got_d = aw_got_q;
    w_got_d  = w_got_q;
    awaddr_d = awaddr_q;
    wdata_d  = wdata_q;
    wstrb0_d = wstrb0_q;
    bresp_d  = bresp_q;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_got_d = 1'b1;
      awaddr_d = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_got_d  = 1'b1;
      wdata_d  = S_AXI_WDATA;
      wstrb0_d = S_AXI_WSTRB[0];
    end
    case (wst_q)
      kiu_pkg::WR_COLLECT: begin
        if (wr_go) begin
          wst_d    = kiu_pkg::WR_RESP;
          bresp_d  = wr_ok ? `KIU_RESP_OKAY : `KIU_RESP_SLVERR;
          aw_got_d = 1'b0;
          w_got_d  = 1'b0;
        end
      end
      default: begin
        if (S_AXI_BREADY) begin
          wst_d = kiu_pkg::WR_COLLECT;
        end
      end
    endcase
    awready_d = !aw_got_d && (wst_d == kiu_pkg::WR_COLLECT);
    wready_d  = !w_got_d && (wst_d == kiu_pkg::WR_COLLECT);
    bvalid_d  = (wst_d == kiu_pkg::WR_RESP);
  end

  // Write channel registers
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      wst_q         <= kiu_pkg::WR_COLLECT;
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= 32'h0000_0000;
      wstrb0_q      <= 1'b0;
      bresp_q       <= `KIU_RESP_OKAY;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
    end else begin
      wst_q         <= wst_d;
      aw_got_q      <= aw_got_d;
      w_got_q       <= w_got_d;
      awaddr_q      <= awaddr_d;
      wdata_q       <= wdata_d;
      wstrb0_q      <= wstrb0_d;
      bresp_q       <= bresp_d;
      S_AXI_AWREADY <= awready_d;
      S_AXI_WREADY  <= wready_d;
      S_AXI_BVALID  <= bvalid_d;
    end
  end
  assign S_AXI_BRESP = bresp_q;

  // ****************************************************************
  // Keypad request core
  // ****************************************************************
  kiu_pkg::kiu_ctrl_t   ctrl_q, ctrl_d;
  logic [`KIU_PINS-1:0] pen_q, pen_d;
  logic [`KIU_PINS-1:0] pin_prev_q;
  logic                 req_q, req_d;
  logic                 ackd_q, ackd_d;
  logic                 prev_low_q;
  logic                 en_low, set, ack_wr, clr_evt, clear_now, lost;

  // Disabled pins count as high, so they neither latch nor hold
  assign en_low  = |(~pin_lvl & pen_q);
  assign set     = en_low && !prev_low_q;
  assign lost    = |(~pin_lvl & pin_prev_q & pen_q) && prev_low_q;
  assign ack_wr  = wr_scr && wdata_q[`KIU_ACK_BIT];
  assign clr_evt = ack_wr || VECTOR_FETCH_I;
  // Level mode waits for acknowledge and release in either order
  assign clear_now = ctrl_q.sens ? ((ackd_q || clr_evt) && !en_low)
                                 : clr_evt;

  // Next request state; a new fall beats a same-cycle clear
  always_comb begin
    ctrl_d = ctrl_q;
    pen_d  = pen_q;
    if (wr_scr) begin
      ctrl_d.mask = wdata_q[`KIU_MASK_BIT];
      ctrl_d.sens = wdata_q[`KIU_SENS_BIT];
    end
    if (wr_pen) begin
      pen_d = wdata_q[`KIU_PINS-1:0];
    end
    req_d  = set || (req_q && !clear_now);
    ackd_d = ctrl_q.sens && !set && req_q && !clear_now && (ackd_q || clr_evt);
  end

  // Request state; reset drops a pending request even with a pin low
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q     <= '0;
      pen_q      <= `KIU_PEN_RST;
      req_q      <= 1'b0;
      ackd_q     <= 1'b0;
      prev_low_q <= 1'b0;
      pin_prev_q <= `KIU_PIN_IDLE;
    end else begin
      ctrl_q     <= ctrl_d;
      pen_q      <= pen_d;
      req_q      <= req_d;
      ackd_q     <= ackd_d;
      prev_low_q <= en_low;
      pin_prev_q <= pin_lvl;
    end
  end

  // CPU request and wake-up; the clock must keep running in stop mode
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      KEY_IRQ_O <= 1'b0;
      WAKE_O    <= 1'b0;
    end else begin
      KEY_IRQ_O <= req_q && !ctrl_q.mask;
      WAKE_O    <= (WAIT_MODE_I || STOP_MODE_I) && req_q && !ctrl_q.mask;
    end
  end

  // ****************************************************************
  // Read channel and sticky events
  // ****************************************************************
  kiu_pkg::kiu_rst_t rst_q, rst_d;
  kiu_pkg::kiu_evt_t evt_q, evt_d, emask_q, emask_d;
  logic [31:0]       rdata_d;
  logic [1:0]        rresp_d;
  logic              rd_go, rd_evt, arready_d, rvalid_d;

  assign rd_go  = (rst_q == kiu_pkg::RD_IDLE) && S_AXI_ARVALID && S_AXI_ARREADY;
  assign rd_evt = rd_go && (S_AXI_ARADDR == `KIU_EVT_OFF);

  // Read mux; upper bits always zero
  always_comb begin
    rdata_d = S_AXI_RDATA;
    rresp_d = S_AXI_RRESP;
    if (!rd_go) begin
      rdata_d = S_AXI_RDATA;
    end else if (S_AXI_ARADDR == `KIU_SCR_OFF) begin
      rdata_d = {28'h000_0000, req_q, 1'b0, ctrl_q.mask, ctrl_q.sens};
      rresp_d = `KIU_RESP_OKAY;
    end else if (S_AXI_ARADDR == `KIU_PEN_OFF) begin
      rdata_d = {28'h000_0000, pen_q};
      rresp_d = `KIU_RESP_OKAY;
    end else if (S_AXI_ARADDR == `KIU_EVT_OFF) begin
      rdata_d = {30'h0000_0000, evt_q};
      rresp_d = `KIU_RESP_OKAY;
    end else if (S_AXI_ARADDR == `KIU_EMASK_OFF) begin
      rdata_d = {30'h0000_0000, emask_q};
      rresp_d = `KIU_RESP_OKAY;
    end else begin
      rdata_d = 32'h0000_0000;
      rresp_d = `KIU_RESP_SLVERR;
    end
  end

  // Read sequence and event bits; a new event outlives the clearing read
  always_comb begin
    rst_d   = rst_q;
    emask_d = emask_q;
    case (rst_q)
      kiu_pkg::RD_IDLE: begin
        if (rd_go) begin
          rst_d = kiu_pkg::RD_RESP;
        end
      end
      default: begin
        if (S_AXI_RREADY) begin
          rst_d = kiu_pkg::RD_IDLE;
        end
      end
    endcase
    arready_d = (rst_d == kiu_pkg::RD_IDLE);
    rvalid_d  = (rst_d == kiu_pkg::RD_RESP);
    evt_d     = rd_evt ? '0 : evt_q;
    evt_d.latched = evt_d.latched || set;
    evt_d.lost    = evt_d.lost || (lost && !ctrl_q.sens);
    if (wr_emask) begin
      emask_d = wdata_q[1:0];
    end
  end

  // Read channel and event registers
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rst_q         <= kiu_pkg::RD_IDLE;
      evt_q         <= '0;
      emask_q       <= '0;
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= `KIU_RESP_OKAY;
      IRQ_O         <= 1'b0;
    end else begin
      rst_q         <= rst_d;
      evt_q         <= evt_d;
      emask_q       <= emask_d;
      S_AXI_ARREADY <= arready_d;
      S_AXI_RVALID  <= rvalid_d;
      S_AXI_RDATA   <= rdata_d;
      S_AXI_RRESP   <= rresp_d;
      IRQ_O         <= |(evt_q & emask_q);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!rst_n);
  sequence s_edge_clear; clr_evt && !ctrl_q.sens && !set; endsequence
  // Window long enough to see a key released and pressed again after a clear
  sequence s_clear_then_fall; clr_evt ##[1:60] set; endsequence

  property p_upper_zero; S_AXI_RVALID |-> S_AXI_RDATA[31:4] == 28'h000_0000; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");
  property p_pend_read;
    rd_go && S_AXI_ARADDR == `KIU_SCR_OFF |=> S_AXI_RDATA[3] == $past(req_q) && !S_AXI_RDATA[2];
  endproperty
  a_pend_read: assert property (p_pend_read) else $error("flag or ack read wrong");
  property p_mask;
    (req_q && !ctrl_q.mask |=> KEY_IRQ_O) and (ctrl_q.mask |=> !KEY_IRQ_O);
  endproperty
  a_mask: assert property (p_mask) else $error("mask not honoured");
  property p_level_hold; req_q && ctrl_q.sens && en_low |=> req_q; endproperty
  a_level_hold: assert property (p_level_hold) else $error("level request dropped");
  property p_latch_cause; $rose(req_q) |-> $past(en_low) && !$past(prev_low_q); endproperty
  a_latch_cause: assert property (p_latch_cause) else $error("latch without fall");
  property p_reset_clear; $rose(rst_n) |-> !req_q && ctrl_q == '0 && pen_q == '0; endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left state");
  property p_wake; (WAIT_MODE_I || STOP_MODE_I) && req_q && !ctrl_q.mask |=> WAKE_O; endproperty
  a_wake: assert property (p_wake) else $error("no wake-up");
  property p_edge_clear; s_edge_clear |=> !req_q; endproperty
  a_edge_clear: assert property (p_edge_clear) else $error("edge clear failed");
  property p_relatch; s_clear_then_fall |=> req_q; endproperty
  a_relatch: assert property (p_relatch) else $error("fall after clear lost");

endmodule : kiu_top

`default_nettype wire

// ===== kiu_keys.sv
// Keypad switch model that drives the four keypad port pins
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Switch bank with pull-ups
// ****************************************************************
module kiu_keys (
  // Key presses from the bench
  input  wire logic [3:0] press_i,
  // Port pins seen by the unit
  output logic      [3:0] pin_o
);
  // A pressed key shorts its pin low; a released key lets the pull-up win
  assign pin_o = ~press_i;
endmodule : kiu_keys

`default_nettype wire

// ===== tb_kiu_top.sv
// Self-checking testbench of the keypad interrupt unit
`timescale 1ns/10ps
`default_nettype none

module tb_kiu_top;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  press = 4'h0;
  logic [3:0]  wstrb = 4'hF;
  logic        vfetch = 1'b0, wait_m = 1'b0, stop_m = 1'b0;
  wire logic   awready, wready, bvalid, arready, rvalid, key_irq, wake, irq;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [3:0]  pins;
  int          n_mismatch = 0;
  int          checks = 0;

  // 100 MHz clock
  always #5 clk = ~clk;

  kiu_keys u_kiu_keys (.press_i(press), .pin_o(pins));

  kiu_top u_kiu_top (
    .CORE_CLK_I(clk), .RESETN_I(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .PORT_PIN_I(pins), .VECTOR_FETCH_I(vfetch), .WAIT_MODE_I(wait_m),
    .STOP_MODE_I(stop_m), .KEY_IRQ_O(key_irq), .WAKE_O(wake), .IRQ_O(irq)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (!aw_done && awready) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (!w_done && wready) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check(bresp, er);
  endtask : wr

  // Read one word and compare data and response
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    check(rdata, exp);
    check(rresp, er);
  endtask : rdc

  // Change keys, then allow for synchroniser and latch delay
  task automatic keys(input logic [3:0] k);
    @(posedge clk);
    press <= k;
    cyc(10);
  endtask : keys

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // ****************************************************************
  // Watchdog: the tests need well under 3000 cycles
  // ****************************************************************
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    cyc(2);
    rst_n <= 1'b1;
    cyc(4);
    // Reset state
    rdc(8'h00, 32'h0000_0000, 2'h0);
    rdc(8'h04, 32'h0000_0000, 2'h0);
    check(key_irq, 1'b0);
    $display("test reset done");
    // Unused bits and write-only acknowledge
    wr(8'h00, 32'h0000_00FF, 2'h0);
    rdc(8'h00, 32'h0000_0003, 2'h0);
    wr(8'h04, 32'h0000_00FF, 2'h0);
    rdc(8'h04, 32'h0000_000F, 2'h0);
    wr(8'h04, 32'h0000_0000, 2'h0);
    wr(8'h00, 32'h0000_0000, 2'h0);
    $display("test fields done");
    // Pin enables, latch, event interrupt, acknowledge in edge mode
    wr(8'h0C, 32'h0000_0001, 2'h0);
    wr(8'h04, 32'h0000_0001, 2'h0);
    keys(4'h2);
    rdc(8'h00, 32'h0000_0000, 2'h0);
    check(irq, 1'b0);
    keys(4'h0);
    keys(4'h1);
    rdc(8'h00, 32'h0000_0008, 2'h0);
    check(key_irq, 1'b1);
    check(irq, 1'b1);
    rdc(8'h08, 32'h0000_0001, 2'h0);
    cyc(2);
    check(irq, 1'b0);
    wr(8'h00, 32'h0000_0004, 2'h0);
    rdc(8'h00, 32'h0000_0000, 2'h0);
    check(key_irq, 1'b0);
    $display("test edge done");
    // Edge while another enabled pin is low, then new edge after release, cleared by vector fetch
    wr(8'h04, 32'h0000_0003, 2'h0);
    keys(4'h3);
    rdc(8'h00, 32'h0000_0000, 2'h0);
    rdc(8'h08, 32'h0000_0002, 2'h0);
    keys(4'h0);
    keys(4'h2);
    rdc(8'h00, 32'h0000_0008, 2'h0);
    @(posedge clk);
    vfetch <= 1'b1;
    @(posedge clk);
    vfetch <= 1'b0;
    cyc(3);
    rdc(8'h00, 32'h0000_0000, 2'h0);
    keys(4'h0);
    rdc(8'h08, 32'h0000_0001, 2'h0);
    $display("test lost edge done");
    // Mask, wait and stop wake-up
    wr(8'h00, 32'h0000_0002, 2'h0);
    keys(4'h1);
    rdc(8'h00, 32'h0000_000A, 2'h0);
    check(key_irq, 1'b0);
    @(posedge clk);
    wait_m <= 1'b1;
    cyc(3);
    check(wake, 1'b0);
    wr(8'h00, 32'h0000_0000, 2'h0);
    cyc(3);
    check(key_irq, 1'b1);
    check(wake, 1'b1);
    wait_m <= 1'b0;
    stop_m <= 1'b1;
    cyc(3);
    check(wake, 1'b1);
    stop_m <= 1'b0;
    cyc(3);
    check(wake, 1'b0);
    wr(8'h00, 32'h0000_0004, 2'h0);
    keys(4'h0);
    $display("test mask done");
    // Level mode: both acknowledge and release, in either order
    wr(8'h00, 32'h0000_0001, 2'h0);
    keys(4'h1);
    rdc(8'h00, 32'h0000_0009, 2'h0);
    wr(8'h00, 32'h0000_0005, 2'h0);
    rdc(8'h00, 32'h0000_0009, 2'h0);
    keys(4'h0);
    rdc(8'h00, 32'h0000_0001, 2'h0);
    keys(4'h1);
    keys(4'h0);
    rdc(8'h00, 32'h0000_0009, 2'h0);
    wr(8'h00, 32'h0000_0005, 2'h0);
    rdc(8'h00, 32'h0000_0001, 2'h0);
    $display("test level done");
    // Masked event interrupt and unmapped address
    wr(8'h00, 32'h0000_0000, 2'h0);
    rdc(8'h08, 32'h0000_0001, 2'h0);
    wr(8'h0C, 32'h0000_0000, 2'h0);
    rdc(8'h0C, 32'h0000_0000, 2'h0);
    keys(4'h1);
    check(irq, 1'b0);
    rdc(8'h08, 32'h0000_0001, 2'h0);
    rdc(8'h10, 32'h0000_0000, 2'h2);
    wr(8'h10, 32'h0000_00FF, 2'h2);
    // Byte lane 0 off: the enables must stay as they are
    wstrb <= 4'h0;
    wr(8'h04, 32'h0000_0000, 2'h0);
    wstrb <= 4'hF;
    rdc(8'h04, 32'h0000_0003, 2'h0);
    $display("test events done");
    // Reset in mid-run with a request latched and a key still held
    check(key_irq, 1'b1);
    @(posedge clk);
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(4);
    check(key_irq, 1'b0);
    rdc(8'h00, 32'h0000_0000, 2'h0);
    rdc(8'h04, 32'h0000_0000, 2'h0);
    $display("test reset again done");
    close_out();
  end
endmodule : tb_kiu_top

`default_nettype wire
